//--- src/cpu_subset_regs.svh
// Opcodes, cycle counts, register offsets and reset values of the core
`ifndef CPU_SUBSET_REGS_SVH
`define CPU_SUBSET_REGS_SVH

// ****************************************************************
// Full opcodes
// ****************************************************************
`define OP_ADC_IMM 8'h69
`define OP_ADC_ZP 8'h65
`define OP_AND_IMM 8'h29
`define OP_AND_ZP 8'h25
`define OP_SHL_ACC 8'h0A
`define OP_SHL_ZP 8'h06
`define OP_BR_CC 8'h90
`define OP_BR_CS 8'hB0
`define OP_BR_ZS 8'hF0
`define OP_BR_ZC 8'hD0
`define OP_BR_NS 8'h30
`define OP_BR_NC 8'h10
`define OP_JUMP_REL 8'h80
`define OP_TEST_ZP 8'h24
`define OP_TEST_ABS 8'h2C
`define OP_SWBREAK 8'h00
`define OP_CLR_C 8'h18
`define OP_CLR_D 8'hD8
`define OP_CLR_I 8'h58
`define OP_CLR_T 8'h12
`define OP_CLR_V 8'hB8
`define OP_CPA_IMM 8'hC9
`define OP_CPA_ZP 8'hC5
`define OP_INV_ZP 8'h44
`define OP_CIX_IMM 8'hE0
`define OP_CIX_ZP 8'hE4
`define OP_CIY_IMM 8'hC0
`define OP_CIY_ZP 8'hC4
`define OP_SUB1_ACC 8'h1A
`define OP_SUB1_ZP 8'hC6

// ****************************************************************
// Bit-numbered opcodes: low five bits, bit number in bits 7..5
// ****************************************************************
`define OPL_BTZ_ACC 5'h13
`define OPL_BTO_ACC 5'h03
`define OPL_BTZ_ZP 5'h17
`define OPL_BTO_ZP 5'h07
`define OPL_BCLR_ACC 5'h1B
`define OPL_BCLR_ZP 5'h1F

// ****************************************************************
// Cycle counts
// ****************************************************************
`define CYC_SHORT 3'd2
`define CYC_ZP 3'd3
`define CYC_ABS 3'd4
`define CYC_RMW 3'd5
`define CYC_SWB 3'd7

// ****************************************************************
// Status bits, stack page, reset values
// ****************************************************************
`define PS_N 7
`define PS_V 6
`define PS_T 5
`define PS_B 4
`define PS_D 3
`define PS_I 2
`define PS_Z 1
`define PS_C 0
`define STACK_PAGE 8'h01
`define RST_PC 16'h0000
`define RST_SP 8'hFF
`define RST_PS 8'h04

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_PC 8'h08
`define REG_ACC 8'h0C
`define REG_XR 8'h10
`define REG_YR 8'h14
`define REG_SP 8'h18
`define REG_PS 8'h1C

`endif

//--- src/cpu_subset_pkg.sv
// Types shared by the core and its arithmetic unit
package cpu_subset_pkg;

  typedef enum logic [3:0] {
    S_HALT, S_FETCH, S_OPER, S_OPER2, S_READ, S_READX,
    S_EXEC, S_PUSH, S_VECL, S_VECH, S_PAD
  } state_t;

  typedef enum logic [4:0] {
    I_ADC, I_AND, I_SHL, I_BTZ, I_BTO, I_BFLG, I_BALW, I_BIT, I_SWB,
    I_BCLR, I_FCLR, I_CPA, I_CIX, I_CIY, I_COM, I_SUB1, I_BAD
  } ins_t;

  typedef enum logic [2:0] {
    M_IMP, M_IMM, M_ZP, M_ABS, M_REL, M_BITA, M_BITZP
  } mode_t;

  typedef struct packed {
    ins_t ins;
    mode_t md;
    logic [2:0] ncyc;
  } dec_t;

endpackage

//--- src/cpu_subset_alu.sv
// Arithmetic and logic unit with status flag update
`timescale 1ns/1ps
`default_nettype none
`include "cpu_subset_regs.svh"
module cpu_subset_alu
(
  input wire cpu_subset_pkg::ins_t ins,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [2:0] bsel,
  input wire logic [7:0] ps_in,
  output logic [7:0] res,
  output logic [7:0] ps_out
);
  import cpu_subset_pkg::*;

  // Result and flags per operation
  always_comb
  begin
    logic [8:0] sum;
    logic setnz;
    sum = 9'h000;
    setnz = 1'b1;
    res = a;
    ps_out = ps_in;
    case (ins)
      I_ADC:
      begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, ps_in[`PS_C]};
        res = sum[7:0];
        ps_out[`PS_C] = sum[8];
        ps_out[`PS_V] = (a[7] == b[7]) && (sum[7] != a[7]);
      end
      I_AND: res = a & b;
      I_SHL:
      begin
        res = {a[6:0], 1'b0};
        ps_out[`PS_C] = a[7];
      end
      I_CPA, I_CIX, I_CIY:
      begin
        sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
        setnz = 1'b0;
        ps_out[`PS_C] = sum[8];
        ps_out[`PS_N] = sum[7];
        ps_out[`PS_Z] = (sum[7:0] == 8'h00);
      end
      I_COM: res = ~a;
      I_SUB1: res = a - 8'h01;
      I_BIT:
      begin
        setnz = 1'b0;
        ps_out[`PS_N] = b[7];
        ps_out[`PS_V] = b[6];
        ps_out[`PS_Z] = ((a & b) == 8'h00);
      end
      I_BCLR:
      begin
        setnz = 1'b0;
        res = a & ~(8'h01 << bsel);
      end
      default: setnz = 1'b0;
    endcase
    // Sign and zero from the stored result
    if (setnz)
    begin
      ps_out[`PS_N] = res[7];
      ps_out[`PS_Z] = (res == 8'h00);
    end
  end

endmodule
`default_nettype wire

//--- src/cpu_subset_core.sv
// Instruction subset execution core with an APB control slave
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_subset_regs.svh"
module cpu_subset_core
#(
  parameter logic [15:0] BRK_VEC = 16'hFFF0,
  parameter logic [7:0] BVC_OP = 8'h50,
  parameter logic [7:0] BVS_OP = 8'h70
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  import cpu_subset_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (BVC_OP == BVS_OP || BVC_OP[4:0] != 5'h10 || BVS_OP[4:0] != 5'h10)
  begin : g_bad_op
    $error("overflow branch opcodes must differ and end in 5'h10");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    state_t st;
    logic [15:0] pc;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] sp;
    logic [7:0] ps;
    dec_t d;
    logic [7:0] op;
    logic tm;
    logic [2:0] cyc;
    logic [15:0] ea;
    logic [7:0] mval;
    logic [1:0] pn;
    logic run;
    logic bad;
    logic [15:0] maddr;
    logic mwe;
    logic [7:0] mwd;
    logic rdy;
    logic err;
    logic [31:0] rdat;
  } core_t;

  core_t s;
  core_t next_s;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_r;
  logic [7:0] alu_ps;
  logic unary;

  // ****************************************************************
  // Decode tables
  // ****************************************************************

  // Opcode to class, addressing and cycle count
  function automatic dec_t decode(input logic [7:0] o);
    dec_t r;
    r = '{I_BAD, M_IMP, `CYC_SHORT};
    case (o[4:0])
      `OPL_BTZ_ACC: r = '{I_BTZ, M_BITA, `CYC_ABS};
      `OPL_BTO_ACC: r = '{I_BTO, M_BITA, `CYC_ABS};
      `OPL_BTZ_ZP: r = '{I_BTZ, M_BITZP, `CYC_RMW};
      `OPL_BTO_ZP: r = '{I_BTO, M_BITZP, `CYC_RMW};
      `OPL_BCLR_ACC: r = '{I_BCLR, M_IMP, `CYC_SHORT};
      `OPL_BCLR_ZP: r = '{I_BCLR, M_ZP, `CYC_RMW};
      default:
      begin
        case (o)
          `OP_ADC_IMM: r = '{I_ADC, M_IMM, `CYC_SHORT};
          `OP_ADC_ZP: r = '{I_ADC, M_ZP, `CYC_ZP};
          `OP_AND_IMM: r = '{I_AND, M_IMM, `CYC_SHORT};
          `OP_AND_ZP: r = '{I_AND, M_ZP, `CYC_ZP};
          `OP_SHL_ACC: r = '{I_SHL, M_IMP, `CYC_SHORT};
          `OP_SHL_ZP: r = '{I_SHL, M_ZP, `CYC_RMW};
          `OP_BR_CC, `OP_BR_CS, `OP_BR_ZS, `OP_BR_ZC, `OP_BR_NS,
          `OP_BR_NC, BVC_OP, BVS_OP: r = '{I_BFLG, M_REL, `CYC_SHORT};
          `OP_JUMP_REL: r = '{I_BALW, M_REL, `CYC_ABS};
          `OP_TEST_ZP: r = '{I_BIT, M_ZP, `CYC_ZP};
          `OP_TEST_ABS: r = '{I_BIT, M_ABS, `CYC_ABS};
          `OP_SWBREAK: r = '{I_SWB, M_IMP, `CYC_SWB};
          `OP_CLR_C, `OP_CLR_D, `OP_CLR_I, `OP_CLR_T,
          `OP_CLR_V: r = '{I_FCLR, M_IMP, `CYC_SHORT};
          `OP_CPA_IMM: r = '{I_CPA, M_IMM, `CYC_SHORT};
          `OP_CPA_ZP: r = '{I_CPA, M_ZP, `CYC_ZP};
          `OP_INV_ZP: r = '{I_COM, M_ZP, `CYC_RMW};
          `OP_CIX_IMM: r = '{I_CIX, M_IMM, `CYC_SHORT};
          `OP_CIX_ZP: r = '{I_CIX, M_ZP, `CYC_ZP};
          `OP_CIY_IMM: r = '{I_CIY, M_IMM, `CYC_SHORT};
          `OP_CIY_ZP: r = '{I_CIY, M_ZP, `CYC_ZP};
          `OP_SUB1_ACC: r = '{I_SUB1, M_IMP, `CYC_SHORT};
          `OP_SUB1_ZP: r = '{I_SUB1, M_ZP, `CYC_RMW};
          default: r = '{I_BAD, M_IMP, `CYC_SHORT};
        endcase
      end
    endcase
    return r;
  endfunction

  // Flag-conditional branch decision
  function automatic logic flag_taken(input logic [7:0] o,
                                      input logic [7:0] p);
    logic t;
    t = 1'b0;
    case (o)
      `OP_BR_CC: t = !p[`PS_C];
      `OP_BR_CS: t = p[`PS_C];
      `OP_BR_ZS: t = p[`PS_Z];
      `OP_BR_ZC: t = !p[`PS_Z];
      `OP_BR_NS: t = p[`PS_N];
      `OP_BR_NC: t = !p[`PS_N];
      BVC_OP: t = !p[`PS_V];
      BVS_OP: t = p[`PS_V];
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // ****************************************************************
  // Operand selection
  // ****************************************************************

  // Single-operand operations work on the accumulator or the fetched byte
  assign unary = (s.d.ins == I_SHL) || (s.d.ins == I_SUB1) ||
                 (s.d.ins == I_COM) || (s.d.ins == I_BCLR);
  assign alu_a = unary ? ((s.d.md == M_IMP) ? s.a : s.mval) :
                 (s.d.ins == I_CIX) ? s.x :
                 (s.d.ins == I_CIY) ? s.y :
                 (s.st == S_READX) ? mem_rdata : s.a;
  assign alu_b = (s.st == S_EXEC || s.st == S_READX) ? s.mval : mem_rdata;

  cpu_subset_alu u_alu
  (
    .ins(s.d.ins),
    .a(alu_a),
    .b(alu_b),
    .bsel(s.op[7:5]),
    .ps_in(s.ps),
    .res(alu_r),
    .ps_out(alu_ps)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Bus slave, sequencer and execution in one next-state process
  always_comb
  begin
    logic [31:0] rv;
    logic hit;
    logic halted;
    logic exec;
    logic done;
    logic wr;
    logic needx;
    logic bitv;
    logic taken;
    dec_t dd;
    rv = 32'h0000_0000;
    hit = 1'b1;
    halted = (s.st == S_HALT);
    exec = 1'b0;
    done = 1'b0;
    wr = 1'b0;
    needx = s.tm && ((s.d.ins == I_ADC) || (s.d.ins == I_AND) ||
                     (s.d.ins == I_CPA));
    bitv = (s.d.md == M_BITA) ? s.a[s.op[7:5]] : s.mval[s.op[7:5]];
    taken = 1'b0;
    dd = decode(mem_rdata);
    next_s = s;
    next_s.mwe = 1'b0;
    next_s.rdy = 1'b0;
    next_s.err = 1'b0;

    // Register read view and decode
    case (paddr)
      `REG_CTRL: rv = {31'h0000_0000, s.run};
      `REG_STAT: rv = {30'h0000_0000, s.bad, halted};
      `REG_PC: rv = {16'h0000, s.pc};
      `REG_ACC: rv = {24'h00_0000, s.a};
      `REG_XR: rv = {24'h00_0000, s.x};
      `REG_YR: rv = {24'h00_0000, s.y};
      `REG_SP: rv = {24'h00_0000, s.sp};
      `REG_PS: rv = {24'h00_0000, s.ps};
      default: hit = 1'b0;
    endcase

    // Answer one cycle into the access phase; write on the pready edge
    if (psel && penable && !s.rdy)
    begin
      next_s.rdy = 1'b1;
      next_s.err = !hit;
      next_s.rdat = rv;
    end
    if (psel && penable && s.rdy && pwrite && hit)
    begin
      case (paddr)
        `REG_CTRL: next_s.run = pwdata[0];
        `REG_STAT: next_s.bad = s.bad && !pwdata[1];
        `REG_PC: next_s.pc = halted ? pwdata[15:0] : s.pc;
        `REG_ACC: next_s.a = halted ? pwdata[7:0] : s.a;
        `REG_XR: next_s.x = halted ? pwdata[7:0] : s.x;
        `REG_YR: next_s.y = halted ? pwdata[7:0] : s.y;
        `REG_SP: next_s.sp = halted ? pwdata[7:0] : s.sp;
        `REG_PS: next_s.ps = halted ? pwdata[7:0] : s.ps;
        default: next_s.run = s.run;
      endcase
    end

    // Instruction sequencer
    case (s.st)
      S_HALT:
      begin
        if (s.run)
        begin
          next_s.st = S_FETCH;
          next_s.maddr = s.pc;
        end
      end
      S_FETCH:
      begin
        next_s.d = dd;
        next_s.op = mem_rdata;
        next_s.tm = s.ps[`PS_T];
        next_s.pc = s.pc + 16'h0001;
        if (dd.ins == I_BAD)
        begin
          next_s.bad = 1'b1;
          next_s.run = 1'b0;
          next_s.st = S_HALT;
        end
        else if (dd.ins == I_SWB)
        begin
          next_s.pc = s.pc + 16'h0002;
          next_s.ps[`PS_B] = 1'b1;
          next_s.maddr = {`STACK_PAGE, s.sp};
          next_s.mwe = 1'b1;
          next_s.mwd = next_s.pc[15:8];
          next_s.sp = s.sp - 8'h01;
          next_s.pn = 2'd1;
          next_s.st = S_PUSH;
        end
        else if (dd.md == M_IMP)
          next_s.st = S_EXEC;
        else
        begin
          next_s.maddr = s.pc + 16'h0001;
          next_s.st = S_OPER;
        end
      end
      S_OPER:
      begin
        next_s.pc = s.pc + 16'h0001;
        next_s.mval = mem_rdata;
        next_s.ea = {8'h00, mem_rdata};
        case (s.d.md)
          M_IMM:
          begin
            if (needx)
            begin
              next_s.maddr = {8'h00, s.x};
              next_s.st = S_READX;
            end
            else
              exec = 1'b1;
          end
          M_ZP, M_BITZP:
          begin
            next_s.maddr = {8'h00, mem_rdata};
            next_s.st = S_READ;
          end
          M_ABS:
          begin
            next_s.maddr = s.pc + 16'h0001;
            next_s.st = S_OPER2;
          end
          default:
          begin
            // Relative byte is on the bus now
            case (s.d.ins)
              I_BTZ: taken = !bitv;
              I_BTO: taken = bitv;
              I_BFLG: taken = flag_taken(s.op, s.ps);
              default: taken = 1'b1;
            endcase
            done = 1'b1;
          end
        endcase
      end
      S_OPER2:
      begin
        next_s.pc = s.pc + 16'h0001;
        if (s.d.md == M_ABS)
        begin
          next_s.ea = {mem_rdata, s.mval};
          next_s.maddr = {mem_rdata, s.mval};
          next_s.st = S_READ;
        end
        else
        begin
          taken = (s.d.ins == I_BTZ) ? !bitv : bitv;
          done = 1'b1;
        end
      end
      S_READ:
      begin
        next_s.mval = mem_rdata;
        if (s.d.md == M_BITZP)
        begin
          next_s.maddr = s.pc;
          next_s.st = S_OPER2;
        end
        else if (needx)
        begin
          next_s.maddr = {8'h00, s.x};
          next_s.st = S_READX;
        end
        else if (unary)
          next_s.st = S_EXEC;
        else
          exec = 1'b1;
      end
      S_READX, S_EXEC: exec = 1'b1;
      S_PUSH:
      begin
        next_s.maddr = {`STACK_PAGE, s.sp};
        next_s.sp = s.sp - 8'h01;
        next_s.mwe = 1'b1;
        next_s.pn = s.pn + 2'd1;
        if (s.pn == 2'd1)
          next_s.mwd = s.pc[7:0];
        else if (s.pn == 2'd2)
        begin
          next_s.mwd = s.ps;
          next_s.ps[`PS_I] = 1'b1;
        end
        else
        begin
          next_s.maddr = BRK_VEC;
          next_s.sp = s.sp;
          next_s.mwe = 1'b0;
          next_s.st = S_VECL;
        end
      end
      S_VECL:
      begin
        next_s.mval = mem_rdata;
        next_s.maddr = BRK_VEC + 16'h0001;
        next_s.st = S_VECH;
      end
      S_VECH:
      begin
        next_s.pc = {mem_rdata, s.mval};
        done = 1'b1;
      end
      S_PAD: done = 1'b1;
      default: next_s.st = S_HALT;
    endcase

    // Taken branch: offset from the address after the relative byte
    if (taken)
      next_s.pc = s.pc + 16'h0001 + {{8{mem_rdata[7]}}, mem_rdata};

    // Execution and destination choice
    if (exec)
    begin
      done = 1'b1;
      case (s.d.ins)
        I_ADC, I_AND:
        begin
          next_s.ps = alu_ps;
          if (s.tm)
          begin
            next_s.maddr = {8'h00, s.x};
            wr = 1'b1;
          end
          else
            next_s.a = alu_r;
        end
        I_CPA, I_CIX, I_CIY, I_BIT: next_s.ps = alu_ps;
        I_SHL, I_SUB1, I_COM, I_BCLR:
        begin
          next_s.ps = alu_ps;
          if (s.d.md == M_IMP)
            next_s.a = alu_r;
          else
          begin
            next_s.maddr = s.ea;
            wr = 1'b1;
          end
        end
        I_FCLR:
        begin
          case (s.op)
            `OP_CLR_C: next_s.ps[`PS_C] = 1'b0;
            `OP_CLR_D: next_s.ps[`PS_D] = 1'b0;
            `OP_CLR_I: next_s.ps[`PS_I] = 1'b0;
            `OP_CLR_T: next_s.ps[`PS_T] = 1'b0;
            default: next_s.ps[`PS_V] = 1'b0;
          endcase
        end
        default: next_s.ps = s.ps;
      endcase
      if (wr)
      begin
        next_s.mwe = 1'b1;
        next_s.mwd = alu_r;
      end
    end

    // End of instruction once its cycle count is used up
    if (done)
    begin
      if (!wr && s.cyc >= s.d.ncyc)
      begin
        next_s.st = s.run ? S_FETCH : S_HALT;
        next_s.maddr = next_s.pc;
      end
      else
        next_s.st = S_PAD;
    end

    // Cycle number within the instruction, fetch is cycle one
    if (next_s.st == S_FETCH)
      next_s.cyc = 3'd1;
    else if (s.cyc != 3'd7)
      next_s.cyc = s.cyc + 3'd1;
  end

  // ****************************************************************
  // Registers and outputs
  // ****************************************************************

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.pc <= `RST_PC;
      s.sp <= `RST_SP;
      s.ps <= `RST_PS;
    end
    else
      s <= next_s;
  end

  // Outputs straight from the state register
  assign prdata = s.rdat;
  assign pready = s.rdy;
  assign pslverr = s.err;
  assign mem_addr = s.maddr;
  assign mem_we = s.mwe;
  assign mem_wdata = s.mwd;

endmodule
`default_nettype wire

//--- sim/mem_model.sv
// Byte memory with same-cycle read on the core's memory port
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
  input wire logic pclk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:65535];
  // Unused bytes hold an unknown opcode so a runaway core halts
  initial for (int i = 0; i < 65536; i++) ram[i] = 8'h02;
  // Read within the cycle, write at the edge
  assign mem_rdata = ram[mem_addr];
  always @(posedge pclk) if (mem_we) ram[mem_addr] <= mem_wdata;
endmodule
`default_nettype wire

//--- sim/core_sva.sv
// Port assertions for the instruction subset core
`timescale 1ns/1ps
`default_nettype none
`include "cpu_subset_regs.svh"
module core_sva
#(
  parameter logic [15:0] BRK_VEC = 16'hFFF0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Break pushes: first stack write, then each one byte lower
  sequence s_push;
    $rose(mem_we) && mem_addr[15:8] == `STACK_PAGE;
  endsequence
  sequence s_next;
    mem_we && mem_addr == $past(mem_addr) - 16'h0001;
  endsequence
  property p_push2;
    s_push |=> s_next;
  endproperty
  a_push2: assert property (p_push2) else $error("push order");
  property p_push_ps;
    s_push ##1 s_next |=> s_next ##0 mem_wdata[`PS_B];
  endproperty
  a_push_ps: assert property (p_push_ps) else $error("pushed B");
  property p_vector;
    s_push ##1 s_next ##1 s_next |=> !mem_we && mem_addr == BRK_VEC
      ##1 !mem_we && mem_addr == BRK_VEC + 16'h0001;
  endproperty
  a_vector: assert property (p_vector) else $error("vector");
  // Writes land only in page zero or the stack page
  property p_we_page;
    mem_we |-> mem_addr[15:9] == 7'h00;
  endproperty
  a_we_page: assert property (p_we_page) else $error("page");
  // A data write goes back to the byte read just before it
  property p_we_src;
    $rose(mem_we) && mem_addr[15:8] == 8'h00 |->
      $past(mem_addr) == mem_addr || $past(mem_addr, 2) == mem_addr;
  endproperty
  a_we_src: assert property (p_we_src) else $error("rmw addr");
  // Bus answer is a one-cycle pulse in an access, error only with it
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready pulse");
  property p_rdy_cause;
    pready |-> psel && penable && $past(psel && penable);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready cause");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error alone");
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench running small programs on the subset core
`timescale 1ns/1ps
`default_nettype none
`include "cpu_subset_regs.svh"
module testbench;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mem_we;
  logic err_s = 0;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  int err_count = 0;
  int n_compared = 0;
  // Clock at 100 MHz
  always #5 pclk = ~pclk;
  cpu_subset_core dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );
  mem_model mem
  (
    .pclk(pclk), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at pready mid-cycle, where it has settled after its edge
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    r = prdata;
    err_s = pslverr;
    chk("pready", {31'h0, pready}, 32'h1);
    // Hold the request through the edge that samples pready high
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(nm, r, {24'h0, e});
  endtask
  task automatic mc(input logic [15:0] a, input logic [7:0] e);
    chk("mem", {24'h0, mem.ram[a]}, {24'h0, e});
  endtask
  task automatic ld(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) mem.ram[a + 16'(i)] = b[i];
  endtask
  // Start at pc and wait until the core halts on the end opcode
  task automatic go(input logic [15:0] pc);
    logic [31:0] r;
    int n;
    n = 0;
    wr(`REG_PC, {16'h0, pc});
    wr(`REG_CTRL, 32'h1);
    do
    begin
      apb(1'b0, `REG_STAT, 32'h0, r);
      n++;
    end
    while (r[0] !== 1'b1 && n < 100);
    chk("halt", {31'h0, r[0]}, 32'h1);
  endtask
  task automatic t_reg;
    logic [31:0] r;
    rc("sp", `REG_SP, 8'hFF);
    rc("ps", `REG_PS, 8'h04);
    apb(1'b0, 8'h40, 32'h0, r);
    chk("err", {31'h0, err_s}, 32'h1);
    chk("rd", r, 32'h0);
    $display("t_reg done");
  endtask
  task automatic t_arith;
    ld(16'h0100, {8'h18, 8'h69, 8'h35, 8'h65, 8'h30, 8'h29, 8'h0F,
      8'h25, 8'h31, 8'hC5, 8'h30, 8'hC9, 8'h04, 8'h02});
    ld(16'h0030, {8'h01, 8'h05});
    wr(`REG_ACC, 32'h10);
    wr(`REG_PS, 32'h05);
    go(16'h0100);
    rc("acc", `REG_ACC, 8'h04);
    rc("ps", `REG_PS, 8'h07);
    $display("t_arith done");
  endtask
  task automatic t_tmode;
    ld(16'h0140, {8'hD8, 8'hB8, 8'h69, 8'h22, 8'h29, 8'hF0, 8'hC9,
      8'h30, 8'h12, 8'h69, 8'h01, 8'h58, 8'h02});
    ld(16'h0040, {8'h11});
    wr(`REG_XR, 32'h40);
    wr(`REG_ACC, 32'h05);
    wr(`REG_PS, 32'h6C);
    go(16'h0140);
    mc(16'h0040, 8'h30);
    rc("acc", `REG_ACC, 8'h07);
    rc("ps", `REG_PS, 8'h00);
    $display("t_tmode done");
  endtask
  task automatic t_rmw;
    ld(16'h0180, {8'h06, 8'h50, 8'h44, 8'h51, 8'hC6, 8'h52, 8'h7F,
      8'h53, 8'h0A, 8'h3B, 8'h1A, 8'h02});
    ld(16'h0050, {8'h81, 8'h0F, 8'h00, 8'hFF});
    wr(`REG_ACC, 32'hC3);
    wr(`REG_PS, 32'h00);
    go(16'h0180);
    mc(16'h0050, 8'h02);
    mc(16'h0051, 8'hF0);
    mc(16'h0052, 8'hFF);
    mc(16'h0053, 8'hF7);
    rc("acc", `REG_ACC, 8'h83);
    rc("ps", `REG_PS, 8'h81);
    $display("t_rmw done");
  endtask
  task automatic t_branch;
    logic [31:0] r;
    ld(16'h0400, {8'h90, 8'h01, 8'h1A, 8'hB0, 8'h01, 8'h1A, 8'h30,
      8'h01, 8'h1A, 8'h10, 8'h01, 8'h1A, 8'hD0, 8'h01, 8'h1A, 8'hF0,
      8'h01, 8'h1A, 8'h50, 8'h01, 8'h1A, 8'h70, 8'h01, 8'h1A, 8'h80,
      8'h01, 8'h1A, 8'h03, 8'h01, 8'h1A, 8'h53, 8'h01, 8'h1A, 8'hE7,
      8'h60, 8'h01, 8'h1A, 8'h17, 8'h60, 8'h01, 8'h1A, 8'h24, 8'h61,
      8'h2C, 8'h61, 8'h00, 8'h70, 8'h01, 8'h1A, 8'h02});
    ld(16'h0060, {8'h80, 8'hC0});
    wr(`REG_ACC, 32'h00);
    wr(`REG_PS, 32'h00);
    go(16'h0400);
    rc("acc", `REG_ACC, 8'hFB);
    rc("ps", `REG_PS, 8'hC0);
    apb(1'b0, `REG_PC, 32'h0, r);
    chk("pc", r, 32'h0432);
    $display("t_branch done");
  endtask
  task automatic t_idx;
    ld(16'h0500, {8'hE0, 8'h10, 8'hE4, 8'h70, 8'hC4, 8'h70, 8'hC0,
      8'h30, 8'h02});
    ld(16'h0070, {8'h10});
    wr(`REG_XR, 32'h10);
    wr(`REG_YR, 32'h20);
    wr(`REG_PS, 32'h00);
    go(16'h0500);
    rc("ps", `REG_PS, 8'h80);
    rc("y", `REG_YR, 8'h20);
    $display("t_idx done");
  endtask
  task automatic t_brk;
    logic [31:0] r;
    ld(16'h0200, {8'h00});
    ld(16'hFFF0, {8'h00, 8'h03});
    wr(`REG_SP, 32'hFF);
    wr(`REG_PS, 32'h00);
    go(16'h0200);
    mc(16'h01FF, 8'h02);
    mc(16'h01FE, 8'h02);
    mc(16'h01FD, 8'h10);
    rc("sp", `REG_SP, 8'hFC);
    apb(1'b0, `REG_PC, 32'h0, r);
    chk("pc", r, 32'h0301);
    apb(1'b0, `REG_PS, 32'h0, r);
    chk("i", {31'h0, r[`PS_I]}, 32'h1);
    $display("t_brk done");
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset for two cycles, then the scenarios
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reg;
    t_arith;
    t_tmode;
    t_rmw;
    t_branch;
    t_idx;
    t_brk;
    give_verdict;
  end
  // Watchdog
  initial
  begin
    #200000;
    err_count++;
    give_verdict;
  end
endmodule
bind cpu_subset_core core_sva #(.BRK_VEC(BRK_VEC)) sva
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
  .mem_we(mem_we), .mem_wdata(mem_wdata)
);
`default_nettype wire
